// ### tbc_t1_boc_controller.sv
/*
 Top of the T1 code controller: host registers, code transmit through
 the generator, code receive with filtering, data link events.
 Assumes one register access per strobe, synchronous link bit strobes
 and a single core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tbc_t1_boc_controller
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic t1Mode,
   input wire logic [7:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData_ff,
   input wire logic linkStrobe,
   input wire logic rxBit,
   output logic txLinkBit_ff,
   output logic eventIrq_ff
);
   import tbc_pkg::*;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] control_ff;
   logic [7:0] mask_ff;
   logic [7:0] txWord_ff;
   logic [7:0] matchA_ff;
   logic [7:0] matchB_ff;
   logic [EV_COUNT-1:0] status_ff;
   logic [EV_COUNT-1:0] evSet;
   logic [5:0] rxCode_ff;
   logic [7:0] rxWord_ff;
   logic [2:0] wordCnt_ff;
   logic rxResetDly_ff;
   logic rxResetPulse;
   logic sendEn;
   logic rxEn;
   logic genBit;
   logic frameDone;
   logic [2:0] required;

   // Tied to code requirements
   // mode gating
   assign sendEn = t1Mode && control_ff[CTL_SEND];
   assign rxEn = t1Mode && control_ff[CTL_RX_EN];

   function automatic logic [2:0] filterCount(input logic [1:0] sel);
      unique case (sel)
         2'b00: filterCount = FILT_NONE;
         2'b01: filterCount = FILT_3;
         2'b10: filterCount = FILT_5;
         2'b11: filterCount = FILT_7;
      endcase
   endfunction

   assign required = filterCount(control_ff[CTL_FILT_HI:CTL_FILT_LO]);

   // ----------------------------------------
   // Host writes
   // ----------------------------------------
   // masks reset zero
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         control_ff <= RST_REG;
         mask_ff <= RST_REG;
         txWord_ff <= RST_REG;
         matchA_ff <= RST_REG;
         matchB_ff <= RST_REG;
      end
      else if (regWr)
      begin
         unique case (regAddr)
            // control and mask upper bits dropped, so they read back as zero
            ADDR_CODE_CONTROL: control_ff <= {3'b000, regWrData[4:0]};
            ADDR_EVENT_MASK: mask_ff <= {2'b00, regWrData[5:0]};
            ADDR_TX_LINK_WORD: txWord_ff <= regWrData;
            ADDR_MATCH_A: matchA_ff <= regWrData;
            ADDR_MATCH_B: matchB_ff <= regWrData;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rxResetDly_ff <= 1'b0;
      else
         rxResetDly_ff <= control_ff[CTL_RX_RESET];
   end
   assign rxResetPulse = control_ff[CTL_RX_RESET] && !rxResetDly_ff;

   // ----------------------------------------
   // Transmit
   // ----------------------------------------
   // code from low six bits
   tbc_code_gen u_gen
   (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .sendEn(sendEn),
      .code(txWord_ff[5:0]),
      .linkStrobe(linkStrobe),
      .txBit(genBit),
      .frameDone(frameDone)
   );

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         txLinkBit_ff <= 1'b1;
      else if (linkStrobe)
         txLinkBit_ff <= genBit;
   end

   // ----------------------------------------
   // Receive shifter and detector
   // ----------------------------------------
   logic [15:0] rxShift_ff;
   logic [4:0] onesRun_ff;
   logic [4:0] clearCnt_ff;
   logic [5:0] candCode_ff;
   logic [2:0] repCnt_ff;
   logic [15:0] nxt_rxShift;
   logic frameSeen;
   logic [5:0] seenCode;

   assign nxt_rxShift = {rxBit, rxShift_ff[15:1]};
   // Oldest bit in [0]: ones, zero, code LSB first, zero
   assign frameSeen = (nxt_rxShift[7:0] == 8'hff) && !nxt_rxShift[8]
                      && !nxt_rxShift[15];
   assign seenCode = nxt_rxShift[14:9];

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rxShift_ff <= 16'h0000;
      else if (linkStrobe)
         rxShift_ff <= nxt_rxShift;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rxCode_ff <= CODE_PRESET;
         candCode_ff <= CODE_PRESET;
         repCnt_ff <= 3'd0;
      end
      else if (!rxEn || rxResetPulse)
      begin
         rxCode_ff <= CODE_PRESET;
         candCode_ff <= CODE_PRESET;
         repCnt_ff <= 3'd0;
      end
      else if (linkStrobe && frameSeen)
      begin
         if (seenCode != candCode_ff || repCnt_ff == 3'd0)
         begin
            candCode_ff <= seenCode;
            repCnt_ff <= 3'd1;
            if (required == FILT_NONE)
               rxCode_ff <= seenCode;
         end
         else
         begin
            if (repCnt_ff != 3'd7)
               repCnt_ff <= repCnt_ff + 3'd1;
            // Widened so a saturated count cannot wrap to zero
            if ({1'b0, repCnt_ff} + 4'd1 >= {1'b0, required})
               rxCode_ff <= candCode_ff;
         end
      end
   end

   // Plain link word assembly, eight bits per word
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rxWord_ff <= 8'h00;
         wordCnt_ff <= 3'd0;
      end
      else if (linkStrobe && t1Mode)
      begin
         wordCnt_ff <= wordCnt_ff + 3'd1;
         if (wordCnt_ff == 3'd7)
            rxWord_ff <= nxt_rxShift[15:8];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         onesRun_ff <= 5'd0;
         clearCnt_ff <= 5'd0;
      end
      else if (linkStrobe && t1Mode)
      begin
         if (!rxBit)
            onesRun_ff <= 5'd0;
         else if (onesRun_ff != ABORT_ONES)
            onesRun_ff <= onesRun_ff + 5'd1;
         if (rxBit && onesRun_ff == ABORT_ONES - 5'd1)
            clearCnt_ff <= 5'd0;
         else if (clearCnt_ff != CLEAR_BITS)
            clearCnt_ff <= clearCnt_ff + 5'd1;
      end
   end

   // ----------------------------------------
   // Events
   // ----------------------------------------
   logic [5:0] prevCode_ff;
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         prevCode_ff <= CODE_PRESET;
      else
         prevCode_ff <= rxCode_ff;
   end

   always_comb
   begin
      evSet = '0;
      evSet[EV_CODE_CHANGE] = rxEn && (rxCode_ff != prevCode_ff);
      evSet[EV_MATCH] = linkStrobe && t1Mode && wordCnt_ff == 3'd7
         && (nxt_rxShift[15:8] == matchA_ff
             || nxt_rxShift[15:8] == matchB_ff);
      evSet[EV_TX_EMPTY] = frameDone;
      evSet[EV_RX_FULL] = linkStrobe && t1Mode && wordCnt_ff == 3'd7;
      evSet[EV_ABORT] = linkStrobe && t1Mode && rxBit
         && onesRun_ff == ABORT_ONES - 5'd1;
      evSet[EV_CLEAR] = linkStrobe && t1Mode && !(rxBit
         && onesRun_ff == ABORT_ONES - 5'd1)
         && clearCnt_ff == CLEAR_BITS - 5'd1;
   end

   // latched until read; set beats clear
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         status_ff <= '0;
      else if (regRd && regAddr == ADDR_EVENT_STATUS)
         status_ff <= evSet;
      else
         status_ff <= status_ff | evSet;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         eventIrq_ff <= 1'b0;
      else
         eventIrq_ff <= |(status_ff & mask_ff[EV_COUNT-1:0]);
   end

   // ----------------------------------------
   // Host reads
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         regRdData_ff <= 8'h00;
      else if (regRd)
      begin
         unique case (regAddr)
            ADDR_EVENT_STATUS: regRdData_ff <= {2'b00, status_ff};
            ADDR_EVENT_MASK: regRdData_ff <= mask_ff;
            ADDR_CODE_CONTROL: regRdData_ff <= control_ff;
            ADDR_RX_LINK_CODE: regRdData_ff <= rxEn ?
               {2'b00, rxCode_ff} : rxWord_ff;
            ADDR_TX_LINK_WORD: regRdData_ff <= txWord_ff;
            ADDR_MATCH_A: regRdData_ff <= matchA_ff;
            ADDR_MATCH_B: regRdData_ff <= matchB_ff;
            default: regRdData_ff <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### tbc_pkg.sv
/*
 Package for the T1 code controller: register offsets, field positions,
 reset values, filter counts and the code frame layout.
 Assumes an 8-bit host register port with byte offsets as printed.
*/
package tbc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_EVENT_STATUS = 8'h24;
   localparam logic [7:0] ADDR_EVENT_MASK = 8'h25;
   localparam logic [7:0] ADDR_CODE_CONTROL = 8'h37;
   localparam logic [7:0] ADDR_RX_LINK_CODE = 8'hc0;
   localparam logic [7:0] ADDR_TX_LINK_WORD = 8'hc1;
   localparam logic [7:0] ADDR_MATCH_A = 8'hc2;
   localparam logic [7:0] ADDR_MATCH_B = 8'hc3;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [5:0] CODE_PRESET = 6'h3f;
   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int CTL_SEND = 0;
   localparam int CTL_FILT_LO = 1;
   localparam int CTL_FILT_HI = 2;
   localparam int CTL_RX_RESET = 3;
   localparam int CTL_RX_EN = 4;
   // ----------------------------------------
   // Status fields
   // ----------------------------------------
   localparam int EV_CODE_CHANGE = 0;
   localparam int EV_MATCH = 1;
   localparam int EV_TX_EMPTY = 2;
   localparam int EV_RX_FULL = 3;
   localparam int EV_ABORT = 4;
   localparam int EV_CLEAR = 5;
   localparam int EV_COUNT = 6;
   // ----------------------------------------
   // Code frame and counts
   // ----------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int FLAG_ONES = 8;
   localparam logic [4:0] ABORT_ONES = 5'd8;
   localparam logic [4:0] CLEAR_BITS = 5'd30;
   localparam logic [2:0] FILT_NONE = 3'd1;
   localparam logic [2:0] FILT_3 = 3'd3;
   localparam logic [2:0] FILT_5 = 3'd5;
   localparam logic [2:0] FILT_7 = 3'd7;
endpackage

// ### tbc_code_gen.sv
/*
 Code generator: shifts out the 16-bit code frame, one bit per link
 strobe, while sending is requested.
 Assumes linkStrobe marks one data link bit slot per pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module tbc_code_gen
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic sendEn,
   input wire logic [5:0] code,
   input wire logic linkStrobe,
   output logic txBit,
   output logic frameDone
);
   import tbc_pkg::*;
   logic [3:0] bitPos_ff;
   logic [15:0] frame;

   // Ones flag, zero, code LSB first, zero
   assign frame = {1'b0, code[5], code[4], code[3], code[2], code[1],
                   code[0], 1'b0, 8'hff};

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         bitPos_ff <= 4'h0;
      else if (!sendEn)
         bitPos_ff <= 4'h0;
      else if (linkStrobe)
         bitPos_ff <= bitPos_ff + 4'h1;
   end

   // Flag bits idle high when not sending
   assign txBit = sendEn ? frame[bitPos_ff] : 1'b1;
   assign frameDone = sendEn && linkStrobe && (bitPos_ff == 4'hf);
endmodule
`default_nettype wire

// ### tbc_checker.sv
/*
 Checker for the T1 code controller: register read-back, event gating
 and link bit timing, seen only at the top module's ports.
 Assumes tbc_pkg and one register access per strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module tbc_checker
   import tbc_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic t1Mode,
   input wire logic [7:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData_ff,
   input wire logic linkStrobe,
   input wire logic rxBit,
   input wire logic txLinkBit_ff,
   input wire logic eventIrq_ff
);
   // ----------------------------------------
   // Shadows of host writes
   // ----------------------------------------
   logic [5:0] maskSh_ff;
   logic [4:0] ctlSh_ff;
   always_ff @(posedge core_clk or negedge arst_n)
      if (!arst_n)
      begin
         maskSh_ff <= 6'h00;
         ctlSh_ff <= 5'h00;
      end
      else if (regWr)
      begin
         if (regAddr == ADDR_EVENT_MASK)
            maskSh_ff <= regWrData[5:0];
         if (regAddr == ADDR_CODE_CONTROL)
            ctlSh_ff <= regWrData[4:0];
      end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_mask_readback: assert property
      (regRd && regAddr == ADDR_EVENT_MASK |=> regRdData_ff[5:0] == maskSh_ff)
      else $error("mask read-back differs");
   chk_mask_upper: assert property
      (regRd && regAddr == ADDR_EVENT_MASK |=> regRdData_ff[7:6] == 2'b00)
      else $error("mask upper bits set");
   chk_ctl_readback: assert property
      (regRd && regAddr == ADDR_CODE_CONTROL |=> regRdData_ff[4:0] == ctlSh_ff)
      else $error("control read-back differs");
   chk_ctl_upper: assert property
      (regRd && regAddr == ADDR_CODE_CONTROL |=> regRdData_ff[7:5] == 3'b000)
      else $error("control upper bits set");
   chk_status_upper: assert property
      (regRd && regAddr == ADDR_EVENT_STATUS |=> regRdData_ff[7:6] == 2'b00)
      else $error("status upper bits set");
   chk_code_upper: assert property
      (regRd && regAddr == ADDR_RX_LINK_CODE && ctlSh_ff[4] && t1Mode
       |=> regRdData_ff[7:6] == 2'b00)
      else $error("received code upper bits set");
   chk_irq_masked: assert property
      ($past(maskSh_ff) == 6'h00 |-> !eventIrq_ff)
      else $error("interrupt with all events masked");
   chk_tx_slot: assert property
      (!$past(linkStrobe) |-> $stable(txLinkBit_ff))
      else $error("link bit moved outside a slot");
   cov_irq: cover property ($rose(eventIrq_ff));
   cov_tx_zero: cover property ($fell(txLinkBit_ff));
   cov_status: cover property
      (regRd && regAddr == ADDR_EVENT_STATUS ##1 regRdData_ff != 8'h00);
endmodule
bind tbc_t1_boc_controller tbc_checker u_chk
(
   .core_clk, .arst_n, .t1Mode, .regAddr, .regWr, .regRd, .regWrData,
   .regRdData_ff, .linkStrobe, .rxBit, .txLinkBit_ff, .eventIrq_ff
);
`default_nettype wire

// ### tbc_remote_model.sv
/*
 Remote line equipment: makes link bit slots, sends codes, all ones or
 an alternating idle, and gathers the last 16 transmitted bits.
 Assumes the block samples rxBit in a slot and answers a cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module tbc_remote_model
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [1:0] mode,
   input wire logic [5:0] code,
   input wire logic txLinkBit_ff,
   output logic linkStrobe,
   output logic rxBit,
   output logic [15:0] txSeen
);
   logic [1:0] div_ff;
   logic [3:0] pos_ff;
   logic due_ff;
   function automatic logic frame_bit(input logic [3:0] p,
                                      input logic [5:0] c);
      if (p < 4'h8)
         return 1'b1;
      if (p == 4'h8 || p == 4'hf)
         return 1'b0;
      return c[p - 4'h9];
   endfunction
   always_ff @(posedge core_clk or negedge arst_n)
      if (!arst_n)
      begin
         div_ff <= 2'h0;
         pos_ff <= 4'h0;
         due_ff <= 1'b0;
         linkStrobe <= 1'b0;
         rxBit <= 1'b0;
         txSeen <= 16'h0000;
      end
      else
      begin
         div_ff <= div_ff + 2'h1;
         linkStrobe <= (div_ff == 2'h0);
         due_ff <= linkStrobe;
         if (due_ff)
            txSeen <= {txLinkBit_ff, txSeen[15:1]};
         if (div_ff == 2'h0)
         begin
            pos_ff <= pos_ff + 4'h1;
            // all ones gives aborts; idle never repeats a bit
            rxBit <= (mode == 2'd2) ? 1'b1 :
               (mode == 2'd1) ? frame_bit(pos_ff, code) : pos_ff[0];
         end
      end
endmodule
`default_nettype wire

// ### test_t1_boc_controller.sv
/*
 Testbench for the T1 code controller: registers, code send, filtered
 code receive and data link events against a remote model.
 Assumes tbc_pkg, the checker bind and a 25 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_t1_boc_controller;
   import tbc_pkg::*;
   logic core_clk, arst_n, t1Mode, regWr, regRd, linkStrobe, rxBit;
   logic [7:0] regAddr, regWrData, regRdData_ff, rdv, hit;
   logic txLinkBit_ff, eventIrq_ff;
   logic [1:0] mode;
   logic [5:0] code;
   logic [15:0] txSeen;
   int error_cnt, checks_done;
   tbc_t1_boc_controller DUT (.core_clk, .arst_n, .t1Mode, .regAddr,
      .regWr, .regRd, .regWrData, .regRdData_ff, .linkStrobe, .rxBit,
      .txLinkBit_ff, .eventIrq_ff);
   tbc_remote_model farEnd (.core_clk, .arst_n, .mode, .code,
      .txLinkBit_ff, .linkStrobe, .rxBit, .txSeen);
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic final_report();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input int wrt, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge core_clk);
      #1;
      regAddr = a;
      regWrData = d;
      regWr = (wrt != 0);
      regRd = (wrt == 0);
      @(posedge core_clk);
      #1;
      regWr = 1'b0;
      regRd = 1'b0;
      rdv = regRdData_ff;
   endtask
   // Bounded waits: irq level, or a whole frame seen on the line
   task automatic wait_irq(input int lim, output int n);
      // Irq flop lags a status read by one edge; skip stale level
      @(posedge core_clk);
      #1;
      for (n = 0; eventIrq_ff !== 1'b1; n++)
      begin
         if (n == lim)
         begin
            chk(8'h00, 8'h01);
            final_report();
         end
         @(posedge core_clk);
         #1;
      end
   endtask
   task automatic wait_tx();
      hit = 8'h00;
      for (int i = 0; i < 400 && hit == 8'h00; i++)
      begin
         @(posedge core_clk);
         #1;
         hit = {7'h00, txSeen[8:0] === 9'h0ff};
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      acc(0, ADDR_EVENT_MASK, 0);
      chk(rdv, RST_REG);
      acc(0, ADDR_CODE_CONTROL, 0);
      chk(rdv, RST_REG);
      acc(0, ADDR_EVENT_STATUS, 0);
      chk(rdv, RST_REG);
      acc(0, ADDR_RX_LINK_CODE, 0);
      chk(rdv, RST_REG);
      acc(0, 8'h10, 0);
      chk(rdv, 8'h00);
      acc(1, ADDR_EVENT_MASK, 8'hff);
      acc(0, ADDR_EVENT_MASK, 0);
      chk(rdv, 8'h3f);
      acc(1, ADDR_EVENT_MASK, 8'h00);
   endtask
   task automatic t_send(input logic [5:0] c);
      int n;
      t1Mode = 1'b0;
      // code first, then send; upper bits must be dropped
      acc(1, ADDR_TX_LINK_WORD, {2'b11, c});
      acc(1, ADDR_CODE_CONTROL, 8'h01);
      wait_tx();
      chk(hit, 8'h00);
      t1Mode = 1'b1;
      wait_tx();
      chk(hit, 8'h01);
      chk({1'b0, txSeen[15:9]}, {2'b00, c});
      acc(1, ADDR_EVENT_MASK, 8'h04);
      acc(0, ADDR_EVENT_STATUS, 0);
      wait_irq(200, n);
      acc(0, ADDR_EVENT_STATUS, 0);
      chk(rdv & 8'h04, 8'h04);
      acc(1, ADDR_CODE_CONTROL, 8'h00);
   endtask
   task automatic t_recv();
      int n, need;
      acc(1, ADDR_EVENT_MASK, 8'h01);
      for (int f = 0; f < 4; f++)
      begin
         need = (f == 0) ? 1 : 2 * f + 1;
         mode = 2'd0;
         acc(1, ADDR_CODE_CONTROL, 8'h00);
         // Idle run breaks every frame, so none straddles the enable
         repeat (68) @(posedge core_clk);
         #1;
         code = 6'h15 ^ f[5:0];
         mode = 2'd1;
         // filter and enable, then read preset
         acc(1, ADDR_CODE_CONTROL, {3'b000, 1'b1, 1'b0, f[1:0], 1'b0});
         acc(0, ADDR_CODE_CONTROL, 0);
         chk(rdv, {3'b000, 1'b1, 1'b0, f[1:0], 1'b0});
         acc(0, ADDR_RX_LINK_CODE, 0);
         chk(rdv, {2'b00, CODE_PRESET});
         acc(0, ADDR_EVENT_STATUS, 0);
         wait_irq(1000, n);
         chk({7'h00, n >= need * 64 - 32 && n <= need * 64 + 80}, 8'h01);
         acc(0, ADDR_RX_LINK_CODE, 0);
         chk(rdv, {2'b00, code});
         acc(0, ADDR_EVENT_STATUS, 0);
         chk(rdv & 8'h01, 8'h01);
         acc(0, ADDR_EVENT_STATUS, 0);
         chk(rdv & 8'h01, 8'h00);
      end
      // Rising reset bit, filter seven: preset returns at once
      acc(1, ADDR_CODE_CONTROL, 8'h1e);
      acc(0, ADDR_RX_LINK_CODE, 0);
      chk(rdv, {2'b00, CODE_PRESET});
   endtask
   task automatic t_events();
      int n;
      acc(1, ADDR_CODE_CONTROL, 8'h00);
      acc(1, ADDR_MATCH_A, 8'haa);
      acc(1, ADDR_MATCH_B, 8'h55);
      mode = 2'd2;
      acc(1, ADDR_EVENT_MASK, 8'h10);
      acc(0, ADDR_EVENT_STATUS, 0);
      wait_irq(200, n);
      acc(0, ADDR_EVENT_STATUS, 0);
      chk(rdv & 8'h10, 8'h10);
      mode = 2'd0;
      acc(1, ADDR_EVENT_MASK, 8'h20);
      acc(0, ADDR_EVENT_STATUS, 0);
      wait_irq(400, n);
      chk({7'h00, n >= 100}, 8'h01);
      acc(0, ADDR_EVENT_STATUS, 0);
      chk(rdv & 8'h2a, 8'h2a);
   endtask
   initial
   begin
      error_cnt = 0;
      checks_done = 0;
      arst_n = 1'b0;
      t1Mode = 1'b1;
      regAddr = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      regWrData = 8'h00;
      mode = 2'd0;
      code = 6'h00;
      repeat (2) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      t_regs();
      t_send(6'h2d);
      t_recv();
      t_events();
      final_report();
   end
endmodule
`default_nettype wire
